// ---- shared/dmsc_defines.svh ----
// Offsets, field positions, reset values and counts of the demodulator control registers
`ifndef DMSC_DEFINES_SVH
`define DMSC_DEFINES_SVH

// Word size and select field
`define DMSC_WORD_BITS 32
`define DMSC_BANK 2'h1
`define DMSC_CODE_STATUS 3'h0
`define DMSC_CODE_SETUP 3'h1
`define DMSC_CODE_CAL 3'h2
`define DMSC_CODE_MIX 3'h3
`define DMSC_CODE_BIAS 3'h5

// Reset images, address bits included
`define DMSC_SETUP_RESET 32'h0000_F009
`define DMSC_CAL_RESET 32'h71E0_200A
`define DMSC_MIX_RESET 32'h4000_000B
`define DMSC_BIAS_RESET 32'h0000_AAAD
`define DMSC_STATUS_ADDR 5'h08

// Address field and writable bits of each register
`define DMSC_ADDR_MASK 32'h0000_001F
`define DMSC_SETUP_MASK 32'h1001_F000
`define DMSC_CAL_MASK 32'hFFFF_FFE0
`define DMSC_MIX_MASK 32'hFFFF_FFE0
`define DMSC_BIAS_MASK 32'h0001_FFE0

// Setup register fields
`define DMSC_GAIN_LSB 12
`define DMSC_GAIN_MULT_BIT 28
`define DMSC_GAIN_MAX 5'h18

// Calibration register fields
`define DMSC_AUTOCAL_BIT 5
`define DMSC_IDAC_LSB 6
`define DMSC_QDAC_LSB 14
`define DMSC_RANGE_LSB 22
`define DMSC_CALSEL_BIT 24
`define DMSC_DIV_LSB 25
`define DMSC_CLKSEL_BIT 28
`define DMSC_TRIM_LSB 29
`define DMSC_DAC_MID 8'h80

// Mixer-load register fields
`define DMSC_I_MIXER_LOAD_SIDE_ONE_LSB 5
`define DMSC_I_MIXER_LOAD_SIDE_TWO_LSB 11
`define DMSC_Q_MIXER_LOAD_SIDE_ONE_LSB 17
`define DMSC_Q_MIXER_LOAD_SIDE_TWO_LSB 23
`define DMSC_BYPASS_BIT 29
`define DMSC_PEAK_LSB 30

// Bias-trim fields start here, two bits each
`define DMSC_BIAS_LSB 5

// Readback request register-select field
`define DMSC_RB_SEL_LSB 27

// Calibration clock divide ratios per code
`define DMSC_DIV_R0 15'h0001
`define DMSC_DIV_R1 15'h0008
`define DMSC_DIV_R2 15'h0010
`define DMSC_DIV_R3 15'h0080
`define DMSC_DIV_R4 15'h0100
`define DMSC_DIV_R5 15'h0400
`define DMSC_DIV_R6 15'h0800
`define DMSC_DIV_R7 15'h412C

`endif

// ---- shared/dmsc_pkg.sv ----
// Types shared by the demodulator control register block
`default_nettype none
package dmsc_pkg;
  // Three-wire programming pins, sampled on core_clk
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic strobe;
  } dmsc_link_t;

  // Control fields presented to the analog side
  typedef struct packed {
    logic autocal_start;
    logic [7:0] manual_i_offset_code;
    logic [7:0] manual_q_offset_code;
    logic [1:0] offset_correction_range;
    logic cal_mode_auto;
    logic [14:0] cal_clk_div_ratio;
    logic cal_clk_internal;
    logic [2:0] osc_trim;
    logic [5:0] i_mixer_load_side_one;
    logic [5:0] i_mixer_load_side_two;
    logic [5:0] q_mixer_load_side_one;
    logic [5:0] q_mixer_load_side_two;
    logic filter_bypass;
    logic [1:0] peaking_ctrl;
    logic [5:0][1:0] bias_trim;
    logic [7:0] live_q_offset_code;
    logic [7:0] live_i_offset_code;
  } dmsc_ctrl_t;

  // Whole state of the register block
  typedef struct packed {
    logic sclk;
    logic strobe;
    logic [31:0] shift;
    logic [31:0] setup;
    logic [31:0] cal;
    logic [31:0] mix;
    logic [31:0] bias;
    logic [7:0] live_q;
    logic [7:0] live_i;
    logic [4:0] gain;
    logic [14:0] ratio;
    logic rb_busy;
    logic rb_idle;
    logic [5:0] rb_cnt;
    logic [31:0] rb_data;
    logic rb_out;
  } dmsc_state_t;
endpackage
`default_nettype wire

// ---- verilog/dmsc_gain_combiner.sv ----
// Baseband gain combiner: programmed gain less the fast-gain pin reduction
`default_nettype none
`include "dmsc_defines.svh"
module dmsc_gain_combiner #(
  parameter int GAIN_BITS = 5
) (
  input wire logic [GAIN_BITS-1:0] programmed_gain,
  input wire logic [2:0] fast_gain_pins,
  input wire logic double_step,
  output logic [GAIN_BITS-1:0] baseband_gain_word
);
  // Clamped gain, reduction in dB and the difference with a borrow bit
  logic [GAIN_BITS-1:0] clamped;
  logic [GAIN_BITS-1:0] reduction;
  logic [GAIN_BITS:0] diff;

  // Pure combinational path; the parent registers the result
  always_comb begin
    // Codes above the top setting act as the top setting
    if (programmed_gain > `DMSC_GAIN_MAX) begin
      clamped = `DMSC_GAIN_MAX;
    end else begin
      clamped = programmed_gain;
    end
    // Each pin step is 1 dB, or 2 dB with the multiplier
    if (double_step) begin
      reduction = GAIN_BITS'({fast_gain_pins, 1'b0});
    end else begin
      reduction = GAIN_BITS'(fast_gain_pins);
    end
    // Subtract the pin value from the programmed gain
    diff = {1'b0, clamped} - {1'b0, reduction};
    // Borrow means the reduction overshot: rail at zero
    if (diff[GAIN_BITS]) begin
      baseband_gain_word = '0;
    end else begin
      baseband_gain_word = diff[GAIN_BITS-1:0];
    end
  end
endmodule
`default_nettype wire

// ---- verilog/dmsc_serial_regs.sv ----
// Serially programmed control registers of the quadrature demodulator
// How it works
// - Words shift in LSB first; strobe loads
// - Readback: one idle clock, then 32 bits
// - Autocal start bit clears itself when done
// - Bits 0-4 pick register and bank
// - Manual Q offset code in bits 14-21
// - Correction range in bits 22-23, resets 11
// - Bit 24 picks manual or automatic calibration
// - Bits 25-27 choose calibration clock divider
// - Bit 28 picks internal oscillator clock
// - Bits 29-31 trim oscillator rate
// - Four six-bit mixer loads, reset zero
// - Bit 29 bypass; peaking bits reset 01
// - Six two-bit bias trims, reset 01
// - Readback request is code zero, bank one
// - Status holds version in bits 5-6
// - Status shows live Q and I codes
// - Five-bit gain in setup bits 12-16
// - Effective gain is programmed minus pins
// - Bit 28 doubles each pin step
// - Effective gain rails at zero
//
// Operating notes
// Serial pins are plain levels sampled on core_clk
// Edges found by comparing against last cycle's level
// Host must hold each pin level one cycle or more
// Shorter pulses would be missed, not half-taken
// Shift register runs on every seen serial clock rise
// Strobe rise copies the shifted word to one register
// Select bits 0-4 decide which register takes it
// Words for another bank leave every register alone
// Address bits of each image are reset constants, rewritten on each write
// So readback always shows the register's own address
// Masked bits are dropped on write and read back zero
// Readback request snapshots the chosen image at once
// Later writes do not change the snapshot being shifted out
// A new strobe rise abandons any readback in progress
// First serial clock after a request is swallowed
// Each following rise moves one image bit to the pin
// Pin holds the final bit once the word is out
// Calibration start bit falls when the engine reports
// A write of the start bit in that cycle still wins
// Live offset codes follow the manual codes when manual
// Engine results replace them when the engine reports
// Gain pins are subtracted live, result registered
// Divider ratio is decoded and registered likewise
// All outputs therefore come straight from flops
// Reset is synchronous and loads the documented images
`default_nettype none
`include "dmsc_defines.svh"
module dmsc_serial_regs #(
  parameter logic [1:0] VERSION_CODE = 2'h2, // Arbitrary version value
  parameter int RB_BITS = 32
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire dmsc_pkg::dmsc_link_t link,
  input wire logic fast_gain_pin_high,
  input wire logic fast_gain_pin_mid,
  input wire logic fast_gain_pin_low,
  input wire logic autocal_done,
  input wire logic [7:0] autocal_q_result,
  input wire logic [7:0] autocal_i_result,
  output logic readback_out,
  output logic [4:0] baseband_gain_word,
  output dmsc_pkg::dmsc_ctrl_t ctrl
);
  import dmsc_pkg::*;

  // Registered state and its next value
  dmsc_state_t st_q;
  dmsc_state_t st_d;

  // Combinational gain from the helper
  logic [4:0] gain_comb;

  // Edge detects on the sampled pins
  logic sclk_rise;
  logic strobe_rise;

  // Word captured in the shift register at strobe time
  logic [31:0] word;

  // Bias trims unpacked by a loop
  logic [5:0][1:0] bias_v;

  // True when a word addresses the given register code in our bank
  function automatic logic hits(input logic [31:0] w, input logic [2:0] code);
    hits = (w[2:0] == code) && (w[4:3] == `DMSC_BANK);
  endfunction

  // Divider code to ratio
  // Table lookup rather than shifts: the top ratio is not a power of two
  // All eight codes are legal, so no default branch
  function automatic logic [14:0] div_ratio(input logic [2:0] code);
    unique case (code)
      3'h0: div_ratio = `DMSC_DIV_R0;
      3'h1: div_ratio = `DMSC_DIV_R1;
      3'h2: div_ratio = `DMSC_DIV_R2;
      3'h3: div_ratio = `DMSC_DIV_R3;
      3'h4: div_ratio = `DMSC_DIV_R4;
      3'h5: div_ratio = `DMSC_DIV_R5;
      3'h6: div_ratio = `DMSC_DIV_R6;
      3'h7: div_ratio = `DMSC_DIV_R7;
    endcase
  endfunction

  // Readback image of one register; unknown codes return zero
  // Status image is assembled from live codes, never stored
  // Codes four, six and seven have no register behind them
  function automatic logic [31:0] image(input logic [2:0] code, input dmsc_state_t s);
    unique case (code)
      `DMSC_CODE_STATUS: image = {s.live_i, s.live_q, 9'h000, VERSION_CODE,
                                  `DMSC_STATUS_ADDR};
      `DMSC_CODE_SETUP: image = s.setup;
      `DMSC_CODE_CAL: image = s.cal;
      `DMSC_CODE_MIX: image = s.mix;
      `DMSC_CODE_BIAS: image = s.bias;
      default: image = 32'h0000_0000;
    endcase
  endfunction

  // Gain combiner sees the stored setup fields and the live pins
  // Pins need no serial rewrite, so a cut lands one cycle later
  dmsc_gain_combiner #(
    .GAIN_BITS(5)
  ) u_gain (
    .programmed_gain(st_q.setup[`DMSC_GAIN_LSB +: 5]),
    .fast_gain_pins({fast_gain_pin_high, fast_gain_pin_mid, fast_gain_pin_low}),
    .double_step(st_q.setup[`DMSC_GAIN_MULT_BIT]),
    .baseband_gain_word(gain_comb)
  );

  // Edge detection against last cycle's pin levels
  assign sclk_rise = link.sclk & ~st_q.sclk;
  assign strobe_rise = link.strobe & ~st_q.strobe;
  assign word = st_q.shift;

  // Next-state logic for the whole block
  always_comb begin
    st_d = st_q;
    // Remember pin levels for edge detection
    st_d.sclk = link.sclk;
    st_d.strobe = link.strobe;

    // Shift in LSB first: first bit lands in bit 0 after 32 clocks
    if (sclk_rise) begin
      st_d.shift = {link.sdata, st_q.shift[31:1]};
    end

    // Readback phase: swallow the idle clock, then one bit per rise
    if (st_q.rb_busy && sclk_rise) begin
      if (st_q.rb_idle) begin
        st_d.rb_idle = 1'b0;
      end else begin
        st_d.rb_out = st_q.rb_data[0];
        st_d.rb_data = {1'b0, st_q.rb_data[31:1]};
        st_d.rb_cnt = st_q.rb_cnt + 6'h01;
        // Last bit driven: leave readback, output holds the last bit
        if (st_q.rb_cnt == 6'(RB_BITS - 1)) begin
          st_d.rb_busy = 1'b0;
        end
      end
    end

    // Calibration engine finished: drop the start bit
    // Clear comes before the strobe branch so a write overrides it
    if (autocal_done) begin
      st_d.cal[`DMSC_AUTOCAL_BIT] = 1'b0;
    end

    // Live DAC codes follow the engine result or the manual codes
    if (autocal_done) begin
      st_d.live_q = autocal_q_result;
      st_d.live_i = autocal_i_result;
    end else if (!st_q.cal[`DMSC_CALSEL_BIT]) begin
      // Manual mode: the programmed codes drive the DACs
      st_d.live_q = st_q.cal[`DMSC_QDAC_LSB +: 8];
      st_d.live_i = st_q.cal[`DMSC_IDAC_LSB +: 8];
    end

    // Strobe rising edge commits the shifted word
    if (strobe_rise) begin
      // Any strobe ends a readback still in progress
      st_d.rb_busy = 1'b0;
      st_d.rb_idle = 1'b0;
      // Only the matching register takes the word
      if (hits(word, `DMSC_CODE_SETUP)) begin
        st_d.setup = (word & `DMSC_SETUP_MASK) |
                     (`DMSC_SETUP_RESET & `DMSC_ADDR_MASK);
      end
      // A start bit written here beats a same-cycle done
      if (hits(word, `DMSC_CODE_CAL)) begin
        st_d.cal = (word & `DMSC_CAL_MASK) |
                   (`DMSC_CAL_RESET & `DMSC_ADDR_MASK);
      end
      if (hits(word, `DMSC_CODE_MIX)) begin
        st_d.mix = (word & `DMSC_MIX_MASK) |
                   (`DMSC_MIX_RESET & `DMSC_ADDR_MASK);
      end
      // Upper bits are unused and never stored
      if (hits(word, `DMSC_CODE_BIAS)) begin
        st_d.bias = (word & `DMSC_BIAS_MASK) |
                    (`DMSC_BIAS_RESET & `DMSC_ADDR_MASK);
      end
      // Register code four is unused; its writes fall through
      // Readback request: latch the chosen image and arm
      if (hits(word, `DMSC_CODE_STATUS)) begin
        st_d.rb_busy = 1'b1;
        st_d.rb_idle = 1'b1;
        st_d.rb_cnt = 6'h00;
        st_d.rb_data = image(word[`DMSC_RB_SEL_LSB +: 3], st_q);
      end
    end

    // Gain and divider ratio are registered so outputs come from flops
    st_d.gain = gain_comb;
    st_d.ratio = div_ratio(st_q.cal[`DMSC_DIV_LSB +: 3]);

    // Synchronous reset wins over everything
    if (reset) begin
      st_d = '0;
      st_d.setup = `DMSC_SETUP_RESET;
      st_d.cal = `DMSC_CAL_RESET;
      st_d.mix = `DMSC_MIX_RESET;
      st_d.bias = `DMSC_BIAS_RESET;
      st_d.live_q = `DMSC_DAC_MID;
      st_d.live_i = `DMSC_DAC_MID;
      // Gain follows the reset setup image, pins apply next cycle
      st_d.gain = 5'(`DMSC_SETUP_RESET >> `DMSC_GAIN_LSB);
      st_d.ratio = `DMSC_DIV_R0;
    end
  end

  // The single state register
  // No reset term here: reset is folded into the next-state logic
  always_ff @(posedge core_clk) begin
    st_q <= st_d;
  end

  // Bias trims repeat in two-bit steps
  // Element zero is the mixer transconductance trim
  generate
    for (genvar k = 0; k < 6; k++) begin : g_bias
      assign bias_v[k] = st_q.bias[`DMSC_BIAS_LSB + 2*k +: 2];
    end
  endgenerate

  // Outputs are slices of the state register
  assign readback_out = st_q.rb_out;
  assign baseband_gain_word = st_q.gain;

  // Control fields to the analog side, all straight from flops
  // Pure wiring: no gates between a flop and any field
  always_comb begin
    ctrl.autocal_start = st_q.cal[`DMSC_AUTOCAL_BIT];
    ctrl.manual_i_offset_code = st_q.cal[`DMSC_IDAC_LSB +: 8];
    ctrl.manual_q_offset_code = st_q.cal[`DMSC_QDAC_LSB +: 8];
    ctrl.offset_correction_range = st_q.cal[`DMSC_RANGE_LSB +: 2];
    ctrl.cal_mode_auto = st_q.cal[`DMSC_CALSEL_BIT];
    ctrl.cal_clk_div_ratio = st_q.ratio;
    ctrl.cal_clk_internal = st_q.cal[`DMSC_CLKSEL_BIT];
    ctrl.osc_trim = st_q.cal[`DMSC_TRIM_LSB +: 3];
    ctrl.i_mixer_load_side_one = st_q.mix[`DMSC_I_MIXER_LOAD_SIDE_ONE_LSB +: 6];
    ctrl.i_mixer_load_side_two = st_q.mix[`DMSC_I_MIXER_LOAD_SIDE_TWO_LSB +: 6];
    ctrl.q_mixer_load_side_one = st_q.mix[`DMSC_Q_MIXER_LOAD_SIDE_ONE_LSB +: 6];
    ctrl.q_mixer_load_side_two = st_q.mix[`DMSC_Q_MIXER_LOAD_SIDE_TWO_LSB +: 6];
    ctrl.filter_bypass = st_q.mix[`DMSC_BYPASS_BIT];
    ctrl.peaking_ctrl = st_q.mix[`DMSC_PEAK_LSB +: 2];
    ctrl.bias_trim = bias_v;
    ctrl.live_q_offset_code = st_q.live_q;
    ctrl.live_i_offset_code = st_q.live_i;
  end
endmodule
`default_nettype wire

// ---- sim/dmsc_serial_regs_chk.sv ----
// Port-level assertions for the demodulator control registers
`default_nettype none
module dmsc_serial_regs_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire dmsc_pkg::dmsc_link_t link,
  input wire logic fast_gain_pin_high,
  input wire logic fast_gain_pin_mid,
  input wire logic fast_gain_pin_low,
  input wire logic autocal_done,
  input wire logic [7:0] autocal_q_result,
  input wire logic [7:0] autocal_i_result,
  input wire logic readback_out,
  input wire logic [4:0] baseband_gain_word,
  input wire dmsc_pkg::dmsc_ctrl_t ctrl
);
  import dmsc_pkg::*;
  wire logic [2:0] pins = {fast_gain_pin_high, fast_gain_pin_mid, fast_gain_pin_low};
  logic strobe_q; // Strobe level of the last cycle, as the block records it
  wire logic commit = link.strobe && !strobe_q; // Word lands at this edge
  // Strobe history, cleared in reset like the block's own
  always_ff @(posedge core_clk) begin
    strobe_q <= reset ? 1'b0 : link.strobe;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_reset_image: assert property (disable iff (1'b0)
    reset |=> !readback_out && baseband_gain_word == 5'h0F && ctrl.peaking_ctrl == 2'h1
    && ctrl.bias_trim == 12'h555 && ctrl.osc_trim == 3'h3 && ctrl.offset_correction_range == 2'h3)
    else $error("reset image wrong");
  a_ctrl_hold: assert property (!$stable({ctrl.osc_trim, ctrl.peaking_ctrl,
    ctrl.bias_trim, ctrl.q_mixer_load_side_two}) |-> $past(commit))
    else $error("control field moved without a strobe");
  a_gain_range: assert property (baseband_gain_word <= 5'h18)
    else $error("gain word above range");
  a_gain_pin_cut: assert property (!$past(commit) && pins > $past(pins) |=>
    baseband_gain_word < $past(baseband_gain_word) || baseband_gain_word == 5'h00)
    else $error("fast gain pins did not cut gain");
  a_ratio_legal: assert property (ctrl.cal_clk_div_ratio inside {15'h0001, 15'h0008,
    15'h0010, 15'h0080, 15'h0100, 15'h0400, 15'h0800, 15'h412C})
    else $error("divider ratio not in table");
  a_autocal_clear: assert property (autocal_done && !commit |=> !ctrl.autocal_start)
    else $error("start bit not cleared");
  a_live_load: assert property (autocal_done |=>
    ctrl.live_q_offset_code == $past(autocal_q_result)
    && ctrl.live_i_offset_code == $past(autocal_i_result))
    else $error("live codes not loaded");
  a_manual_follow: assert property (!ctrl.cal_mode_auto && !autocal_done && !commit |=>
    ctrl.live_q_offset_code == ctrl.manual_q_offset_code)
    else $error("live code ignores manual code");
  a_rb_timing: assert property ($changed(readback_out) |->
    ($past(link.sclk, 2) && !$past(link.sclk, 3)) || ($past(link.sclk) && !$past(link.sclk, 2))
    || $past(commit) || $past(commit, 2))
    else $error("readback bit moved off a clock rise");
endmodule
bind dmsc_serial_regs dmsc_serial_regs_chk dmsc_serial_regs_chk_inst (.core_clk, .reset,
  .link, .fast_gain_pin_high, .fast_gain_pin_mid, .fast_gain_pin_low, .autocal_done,
  .autocal_q_result, .autocal_i_result, .readback_out, .baseband_gain_word, .ctrl);
`default_nettype wire

// ---- sim/dmsc_host.sv ----
// Host model driving the three-wire programming link
`default_nettype none
module dmsc_host (
  input wire logic core_clk,
  input wire logic readback_out,
  output var dmsc_pkg::dmsc_link_t link
);
  import dmsc_pkg::*;
  logic rb_bit; // Readback level seen before the falling edge
  // Idle link: all three pins low
  initial link = '0;
  // One clock pulse; each level held three cycles, above the one the block needs
  task automatic pulse(input logic b);
    link.sdata <= b; // Data settles while the clock is low
    repeat (3) @(posedge core_clk);
    link.sclk <= 1'b1;
    repeat (3) @(posedge core_clk);
    rb_bit = readback_out; // Taken at the falling edge
    link.sclk <= 1'b0;
  endtask
  // Whole word bit 0 first, then a strobe pulse to commit it
  task automatic put_word(input logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      pulse(w[i]);
    end
    repeat (3) @(posedge core_clk);
    link.strobe <= 1'b1;
    repeat (3) @(posedge core_clk);
    link.strobe <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // Request word, one idle clock, then 32 bits bit 0 first
  task automatic read_reg(input logic [2:0] sel, output logic [31:0] data);
    put_word({2'h0, sel, 27'h000_0008});
    pulse(1'b0); // Idle clock
    for (int i = 0; i < 32; i++) begin
      pulse(i[0]);
      data[i] = rb_bit;
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/test_demod_serial_control_registers.sv ----
// Self-checking bench for the demodulator control registers
`default_nettype none
module test_demod_serial_control_registers;
  timeunit 1ns;
  timeprecision 1ps;
  import dmsc_pkg::*;
  typedef struct packed {
    logic [31:0] wr;
    logic [2:0] sel;
    logic [31:0] exp;
  } dmsc_row_t;
  // Word written, register read back, image expected; bank 0 words are refused
  localparam dmsc_row_t ROWS [12] = '{
    '{32'h0000_0000, 3'h0, 32'h8080_0048},
    '{32'h0000_0000, 3'h1, 32'h0000_F009},
    '{32'h0000_0000, 3'h2, 32'h71E0_200A},
    '{32'h0000_0000, 3'h3, 32'h4000_000B},
    '{32'h0000_0000, 3'h5, 32'h0000_AAAD},
    '{32'h0000_0000, 3'h4, 32'h0000_0000},
    '{32'hFFFE_C9CD, 3'h5, 32'h0000_C9CD},
    '{32'h2000_000B, 3'h3, 32'h2000_000B},
    '{32'hFFFF_FFCA, 3'h2, 32'hFFFF_FFCA},
    '{32'hFFFF_0012, 3'h2, 32'hFFFF_FFCA},
    '{32'hFFFF_FF0E, 3'h1, 32'h0000_F009},
    '{32'h1FF1_4FE9, 3'h1, 32'h1001_4009}};
  // Setup words: gain 20 doubled, gain 30 single, gain 5 doubled
  localparam logic [31:0] GSET [3] = '{32'h1001_4009, 32'h0001_E009, 32'h1000_5009};
  logic core_clk;
  logic reset;
  logic [2:0] pins; // Fast gain pins, high to low
  logic autocal_done;
  logic [7:0] q_res;
  logic [7:0] i_res;
  logic readback_out;
  logic [4:0] gain_word;
  dmsc_ctrl_t ctrl;
  dmsc_link_t link;
  logic [31:0] rb; // Last register image read back
  int mismatches;
  int samples_checked;
  dmsc_serial_regs dmsc_serial_regs_inst (.core_clk(core_clk), .reset(reset), .link(link),
    .fast_gain_pin_high(pins[2]), .fast_gain_pin_mid(pins[1]), .fast_gain_pin_low(pins[0]),
    .autocal_done(autocal_done), .autocal_q_result(q_res), .autocal_i_result(i_res),
    .readback_out(readback_out), .baseband_gain_word(gain_word), .ctrl(ctrl));
  dmsc_host dmsc_host_inst (.core_clk(core_clk), .readback_out(readback_out), .link(link));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (50000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end
  // Main sequence
  initial begin
    int g;
    int r;
    mismatches = 0;
    samples_checked = 0;
    reset = 1'b1;
    pins = 3'h0;
    autocal_done = 1'b0;
    q_res = 8'h00;
    i_res = 8'h00;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    foreach (ROWS[i]) begin
      dmsc_host_inst.put_word(ROWS[i].wr);
      dmsc_host_inst.read_reg(ROWS[i].sel, rb);
      check("readback", rb, ROWS[i].exp);
    end
    check("ratio", 32'(ctrl.cal_clk_div_ratio), 32'h0000_412C);
    check("bias", 32'(ctrl.bias_trim), 32'h0000_064E);
    check("bypass", 32'({ctrl.filter_bypass, ctrl.peaking_ctrl}), 32'h0000_0004);
    check("osc", 32'({ctrl.osc_trim, ctrl.cal_clk_internal}), 32'h0000_000F);
    // Every pin value under each setup; gain is registered, so wait it out
    foreach (GSET[s]) begin
      dmsc_host_inst.put_word(GSET[s]);
      for (int p = 0; p < 8; p++) begin
        pins <= 3'(p);
        repeat (3) @(posedge core_clk);
        g = (GSET[s][16:12] > 5'h18) ? 24 : int'(GSET[s][16:12]);
        r = p * (GSET[s][28] ? 2 : 1);
        check("gain", 32'(gain_word), 32'((g > r) ? g - r : 0));
      end
    end
    // Autocal start, then the engine finishing
    dmsc_host_inst.put_word(32'h7100_002A);
    check("start", 32'(ctrl.autocal_start), 32'h0000_0001);
    autocal_done <= 1'b1;
    q_res <= 8'h3C;
    i_res <= 8'hA5;
    @(posedge core_clk);
    autocal_done <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("start", 32'(ctrl.autocal_start), 32'h0000_0000);
    dmsc_host_inst.read_reg(3'h0, rb);
    check("status", rb, 32'hA53C_0048);
    // Manual mode: live codes follow the written codes
    dmsc_host_inst.put_word(32'h0004_488A);
    dmsc_host_inst.read_reg(3'h0, rb);
    check("status", rb, 32'h2211_0048);
    // Second reset in mid-run
    reset <= 1'b1;
    pins <= 3'h0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("gain", 32'(gain_word), 32'h0000_000F);
    end_of_test();
  end
endmodule
`default_nettype wire
